// *** design/ddcf_pkg.sv ***
package ddcf_pkg;
  localparam int          NUM_CH        = 4;
  localparam int          DATA_W        = 16;
  localparam int          EXP_W         = 3;
  localparam int          DLY_W         = 3;
  localparam int          APB_AW        = 8;
  // Register byte offsets; status words follow the control words.
  localparam logic [7:0]  CTRL_BASE     = 8'h00;
  localparam logic [7:0]  STAT_BASE     = 8'h10;
  localparam logic [7:0]  REG_STRIDE    = 8'h04;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  // Control field positions.
  localparam int          MODE_BIT      = 3;
  localparam int          DLY_LSB       = 4;
  localparam int          DLY_MSB       = 6;
  localparam int          GRP_LSB       = 7;
  localparam int          GRP_MSB       = 8;
  localparam int          FLOAT_BIT     = 9;
  // Mantissa grouping codes.
  localparam logic [1:0]  GRP_11_3      = 2'h0;
  localparam logic [1:0]  GRP_12_3      = 2'h1;
  localparam logic [1:0]  GRP_13_3      = 2'h2;
  localparam logic [1:0]  GRP_14_2      = 2'h3;
  // Status field positions.
  localparam int          STAT_ARMED    = 16;
  localparam int          STAT_EXP_LSB  = 17;
endpackage

// *** design/ddcf_input_demux.sv ***
// Overview of operation
// - Select 01: mantissa 15:4, exponent 2:0.
// - Select 10: mantissa 15:3, exponent 2:0.
// - Select 11: mantissa 15:2, exponent 1:0.
// - Delay field 6:4 sets capture wait after strobe.
// - Pick one of up to eight streams.
// - Codes 000 to 111 give 0 to 7 clocks.
// - Captured sample realigned to next strobe, zero delay.
// - Gated mode: oscillator and comb advance on strobe.
// - Interpolated mode: comb updates every clock.
// - Interpolated mode: oscillator still advances on strobe.
// - Interpolated mode: input zeroed while strobe high.
// - Select 00: mantissa 15:5, exponent 2:0.
// - Split only when floating bit 9 set.
`timescale 1ns/1ps

module ddcf_channel
  import ddcf_pkg::*;
(
  input  wire logic                CORE_CLK,
  input  wire logic                RST_N,
  input  wire logic [DATA_W-1:0]   DATA_IN,
  input  wire logic                STROBE_IN,
  input  wire logic [15:0]         CTRL,
  output logic      [DATA_W-1:0]   SAMPLE_OUT,
  output logic      [EXP_W-1:0]    EXP_OUT,
  output logic                     COMB_EN,
  output logic                     OSC_EN,
  output logic                     ARMED
);
  logic [DLY_W-1:0]  dly_reg;
  logic [DLY_W-1:0]  dly_next;
  logic              armed_reg;
  logic              armed_next;
  logic [DATA_W-1:0] cap_reg;
  logic [DATA_W-1:0] cap_next;
  logic [DATA_W-1:0] align_reg;
  logic [DATA_W-1:0] align_next;
  logic [DATA_W-1:0] out_reg;
  logic [DATA_W-1:0] out_next;
  logic [EXP_W-1:0]  exp_reg;
  logic [EXP_W-1:0]  exp_next;
  logic              comb_reg;
  logic              osc_reg;

  wire logic [DLY_W-1:0] dly_sel   = CTRL[DLY_MSB:DLY_LSB];
  wire logic [1:0]       grp_sel   = CTRL[GRP_MSB:GRP_LSB];
  wire logic             float_en  = CTRL[FLOAT_BIT];
  wire logic             interp    = CTRL[MODE_BIT];

  // A zero delay captures on the strobe itself; otherwise the counter runs down.
  wire logic             cap_now   = (STROBE_IN && dly_sel == '0) ||
                                     (armed_reg && dly_reg == 3'h1);

  assign dly_next   = STROBE_IN ? dly_sel :
                      (armed_reg ? dly_reg - 3'h1 : dly_reg);
  assign armed_next = STROBE_IN ? (dly_sel != '0) :
                      (armed_reg && dly_reg != 3'h1);
  assign cap_next   = cap_now ? DATA_IN : cap_reg;
  // The previous capture moves up on each strobe, so every delay code lands
  // at the same point relative to the strobe.
  assign align_next = STROBE_IN ? cap_reg : align_reg;

  // Mantissa is kept left-justified with the unused low bits cleared.
  logic [DATA_W-1:0] mant_w;
  logic [EXP_W-1:0]  exp_w;
  always_comb begin
    mant_w = align_next;
    exp_w  = '0;
    if (float_en) begin
      case (grp_sel)
        GRP_11_3: begin
          mant_w = {align_next[15:5], 5'h00};
          exp_w  = align_next[2:0];
        end
        GRP_12_3: begin
          mant_w = {align_next[15:4], 4'h0};
          exp_w  = align_next[2:0];
        end
        GRP_13_3: begin
          mant_w = {align_next[15:3], 3'h0};
          exp_w  = align_next[2:0];
        end
        GRP_14_2: begin
          mant_w = {align_next[15:2], 2'h0};
          exp_w  = {1'b0, align_next[1:0]};
        end
        default: begin
          mant_w = align_next;
          exp_w  = '0;
        end
      endcase
    end
  end

  // Zero stuffing on strobe clocks keeps the comb gain the same in both modes.
  assign out_next = (interp && STROBE_IN) ? '0 : mant_w;
  assign exp_next = (interp && STROBE_IN) ? '0 : exp_w;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dly_reg   <= '0;
      armed_reg <= 1'b0;
      cap_reg   <= '0;
      align_reg <= '0;
    end else begin
      dly_reg   <= dly_next;
      armed_reg <= armed_next;
      cap_reg   <= cap_next;
      align_reg <= align_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_reg  <= '0;
      exp_reg  <= '0;
      comb_reg <= 1'b0;
      osc_reg  <= 1'b0;
    end else begin
      out_reg  <= out_next;
      exp_reg  <= exp_next;
      comb_reg <= interp ? 1'b1 : STROBE_IN;
      osc_reg  <= STROBE_IN;
    end
  end

  assign SAMPLE_OUT = out_reg;
  assign EXP_OUT    = exp_reg;
  assign COMB_EN    = comb_reg;
  assign OSC_EN     = osc_reg;
  assign ARMED      = armed_reg;
endmodule // ddcf_channel

`timescale 1ns/1ps

// Two-flop synchroniser; nothing outside reads the first stage, so a
// metastable first flop never reaches the channel logic.
module ddcf_sync2
  import ddcf_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  input  wire logic [WIDTH-1:0] ASYNC_VAL,
  output logic      [WIDTH-1:0] SYNC_VAL
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= ASYNC_VAL;
      s2_reg <= s1_reg;
    end
  end

  assign SYNC_VAL = s2_reg;
endmodule // ddcf_sync2

`timescale 1ns/1ps

// One channel's control word. Each byte lane has its own strobe, so software
// can write the float bit without disturbing delay and mode; grouping bits 8:7 straddle both byte lanes.
module ddcf_ctrl_reg
  import ddcf_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = CTRL_RESET
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        WR_EN,
  input  wire logic [1:0]  BYTE_EN,
  input  wire logic [15:0] WDATA,
  output logic      [15:0] VALUE
);
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;

  assign ctrl_next[7:0]  = (WR_EN && BYTE_EN[0]) ? WDATA[7:0]  : ctrl_reg[7:0];
  assign ctrl_next[15:8] = (WR_EN && BYTE_EN[1]) ? WDATA[15:8] : ctrl_reg[15:8];

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= RESET_VAL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign VALUE = ctrl_reg;
endmodule // ddcf_ctrl_reg

`timescale 1ns/1ps

module ddcf_input_demux
  import ddcf_pkg::*;
(
  input  wire logic                      CORE_CLK,
  input  wire logic                      RST_N,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [APB_AW-1:0]         PADDR,
  input  wire logic [31:0]               PWDATA,
  input  wire logic [3:0]                PSTRB,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic [NUM_CH*DATA_W-1:0]  DATA_IN,
  input  wire logic [NUM_CH-1:0]         SAMPLE_STROBE_IN,
  output logic      [NUM_CH*DATA_W-1:0]  SAMPLE_OUT,
  output logic      [NUM_CH*EXP_W-1:0]   EXP_OUT,
  output logic      [NUM_CH-1:0]         COMB_EN,
  output logic      [NUM_CH-1:0]         OSC_EN
);
  // Pin inputs pass two flops; data and strobe share the same latency so
  // their alignment at the pins is kept.
  logic [NUM_CH*DATA_W-1:0] data_sync;
  logic [NUM_CH-1:0]        strb_sync;

  ddcf_sync2 #(
    .WIDTH (NUM_CH*DATA_W)
  ) u_data_sync (
    .CORE_CLK  (CORE_CLK),
    .RST_N     (RST_N),
    .ASYNC_VAL (DATA_IN),
    .SYNC_VAL  (data_sync)
  );

  ddcf_sync2 #(
    .WIDTH (NUM_CH)
  ) u_strb_sync (
    .CORE_CLK  (CORE_CLK),
    .RST_N     (RST_N),
    .ASYNC_VAL (SAMPLE_STROBE_IN),
    .SYNC_VAL  (strb_sync)
  );

  // APB decode: zero wait states, error on unmapped or misaligned addresses.
  wire logic       apb_acc   = PSEL && PENABLE;
  wire logic [1:0] reg_idx   = PADDR[3:2];
  wire logic       hit_ctrl  = (PADDR[7:4] == CTRL_BASE[7:4]) && (PADDR[1:0] == 2'h0);
  wire logic       hit_stat  = (PADDR[7:4] == STAT_BASE[7:4]) && (PADDR[1:0] == 2'h0);
  wire logic       mapped    = hit_ctrl || hit_stat;
  // Status is read-only, so a write to it is refused as well.
  wire logic       wr_ok     = apb_acc && PWRITE && hit_ctrl;

  logic [15:0]     ctrl_reg  [NUM_CH];
  logic [NUM_CH-1:0] armed_w;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      wire logic wr_this = wr_ok && (reg_idx == 2'(g));
      ddcf_ctrl_reg u_ctrl (
        .CORE_CLK (CORE_CLK),
        .RST_N    (RST_N),
        .WR_EN    (wr_this),
        .BYTE_EN  (PSTRB[1:0]),
        .WDATA    (PWDATA[15:0]),
        .VALUE    (ctrl_reg[g])
      );

      ddcf_channel u_ch (
        .CORE_CLK   (CORE_CLK),
        .RST_N      (RST_N),
        .DATA_IN    (data_sync[g*DATA_W +: DATA_W]),
        .STROBE_IN  (strb_sync[g]),
        .CTRL       (ctrl_reg[g]),
        .SAMPLE_OUT (SAMPLE_OUT[g*DATA_W +: DATA_W]),
        .EXP_OUT    (EXP_OUT[g*EXP_W +: EXP_W]),
        .COMB_EN    (COMB_EN[g]),
        .OSC_EN     (OSC_EN[g]),
        .ARMED      (armed_w[g])
      );
    end
  endgenerate

  // Status word: presented sample, exponent and capture-pending flag.
  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    case (reg_idx)
      2'h0: stat_word = {12'h000, EXP_OUT[0*EXP_W +: EXP_W], armed_w[0],
                         SAMPLE_OUT[0*DATA_W +: DATA_W]};
      2'h1: stat_word = {12'h000, EXP_OUT[1*EXP_W +: EXP_W], armed_w[1],
                         SAMPLE_OUT[1*DATA_W +: DATA_W]};
      2'h2: stat_word = {12'h000, EXP_OUT[2*EXP_W +: EXP_W], armed_w[2],
                         SAMPLE_OUT[2*DATA_W +: DATA_W]};
      2'h3: stat_word = {12'h000, EXP_OUT[3*EXP_W +: EXP_W], armed_w[3],
                         SAMPLE_OUT[3*DATA_W +: DATA_W]};
      default: stat_word = '0;
    endcase
  end

  wire logic [31:0] ctrl_word = {16'h0000, ctrl_reg[reg_idx]};

  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc && (!mapped || (PWRITE && hit_stat));
  assign PRDATA  = (apb_acc && !PWRITE && hit_ctrl) ? ctrl_word :
                   (apb_acc && !PWRITE && hit_stat) ? stat_word : 32'h0000_0000;
endmodule // ddcf_input_demux

// *** tb/ddcf_checker.sv ***
`timescale 1ns/1ps

module ddcf_checker
  import ddcf_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RST_N,
  input wire logic [NUM_CH-1:0] SAMPLE_STROBE_IN,
  input wire logic [NUM_CH-1:0] COMB_EN,
  input wire logic [NUM_CH-1:0] OSC_EN
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // Strobe pins pass two sync flops and one output register.
  chk_osc_lat0: assert property (SAMPLE_STROBE_IN[0] |-> ##3 OSC_EN[0])
    else $error("ch0 oscillator pulse missing");
  chk_osc_src0: assert property (OSC_EN[0] |-> $past(SAMPLE_STROBE_IN[0], 3))
    else $error("ch0 oscillator pulse without strobe");
  chk_osc_pulse: assert property (OSC_EN[0] |=> !OSC_EN[0])
    else $error("ch0 oscillator pulse too long");
  chk_comb_osc: assert property (OSC_EN[0] |-> COMB_EN[0])
    else $error("ch0 comb idle on strobe");
  chk_comb_every: assert property ((COMB_EN[0] && !OSC_EN[0]) |=> COMB_EN[0] [*3])
    else $error("ch0 comb stalled in interpolated mode");
  chk_osc_lat1: assert property (SAMPLE_STROBE_IN[1] |-> ##3 OSC_EN[1])
    else $error("ch1 oscillator pulse missing");
  chk_osc_lat2: assert property (SAMPLE_STROBE_IN[2] |-> ##3 OSC_EN[2])
    else $error("ch2 oscillator pulse missing");
  chk_osc_src3: assert property (OSC_EN[3] |-> $past(SAMPLE_STROBE_IN[3], 3))
    else $error("ch3 oscillator pulse without strobe");
  cov_osc: cover property (OSC_EN[0]);
  cov_interp: cover property (COMB_EN[0] && !OSC_EN[0]);
  cov_ch3: cover property (OSC_EN[3]);
endmodule // ddcf_checker

bind ddcf_input_demux ddcf_checker ddcf_checker_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SAMPLE_STROBE_IN(SAMPLE_STROBE_IN),
  .COMB_EN(COMB_EN), .OSC_EN(OSC_EN));

// *** tb/ddcf_source_model.sv ***
`timescale 1ns/1ps

module ddcf_source_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  output logic      [63:0] data,
  output logic      [3:0]  strobe
);
  logic [2:0] slot;
  // Eight streams share each bus; the word changes every clock.
  function automatic logic [15:0] pat(input logic [1:0] n, input logic [2:0] k);
    return {4'h9, n, 2'h0, 1'b1, k, 1'b0, ~k};
  endfunction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) slot <= 3'h0;
    else slot <= slot + 3'h1;
  end
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      strobe[n] = rst_n && (slot == 3'(n));
      data[16*n +: 16] = pat(2'(n), slot - 3'(n));
    end
  end
endmodule // ddcf_source_model

// *** tb/ddcf_input_demux_tb_top.sv ***
`timescale 1ns/1ps

module ddcf_input_demux_tb_top
  import ddcf_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, strobe, comb, osc;
  logic [63:0] din, sout;
  logic [11:0] eout;
  logic er;
  int fail_count, tests_run, cyc;
  ddcf_input_demux ddcf_input_demux_inst (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DATA_IN(din),
    .SAMPLE_STROBE_IN(strobe), .SAMPLE_OUT(sout), .EXP_OUT(eout), .COMB_EN(comb),
    .OSC_EN(osc));
  ddcf_source_model src (.clk(clk), .rst_n(rst_n), .data(din), .strobe(strobe));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_osc(input int n, input int ch);
    repeat (n) begin
      do @(negedge clk); while (osc[ch] !== 1'b1);
    end
  endtask
  task automatic t_regs();
    apb(1'b1, 8'h08, 32'hFFFF_A5F0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0000_A5F0);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, {16'h0, CTRL_RESET});
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h10, 32'h0000_0008);
    chk({31'h0, er}, 32'h1);
  endtask
  // Each pass picks a delay, grouping and format for ch0 and a fixed-point delay for ch1.
  task automatic t_fmt();
    logic [15:0] raw, m;
    logic [2:0] d;
    logic [1:0] g;
    for (int i = 0; i < 9; i++) begin
      d = 3'(i);
      g = 2'(i);
      apb(1'b1, 8'h00, {22'h0, (i != 8), g, d, 4'h0});
      apb(1'b1, 8'h04, {25'h0, 3'h7 - d, 4'h0});
      wait_osc(3, 0);
      raw = src.pat(2'h0, d);
      m = (i == 8) ? raw : raw & (16'hFFFF << (5 - g));
      chk(sout[15:0], m);
      chk(eout[2:0], (i == 8) ? 3'h0 : (g == 2'h3) ? {1'b0, raw[1:0]} : raw[2:0]);
      chk(sout[31:16], src.pat(2'h1, 3'h7 - d));
    end
  endtask
  task automatic t_interp();
    int nc, no, nz;
    nc = 0; no = 0; nz = 0;
    repeat (8) begin
      @(negedge clk);
      nc += (comb[0] === 1'b1);
    end
    chk(nc, 1);
    nc = 0;
    apb(1'b1, 8'h00, 32'h0000_0008);
    wait_osc(2, 0);
    repeat (8) begin
      @(negedge clk);
      nc += (comb[0] === 1'b1);
      no += (osc[0] === 1'b1);
      nz += (sout[15:0] === 16'h0);
    end
    chk(nc, 8);
    chk(no, 1);
    chk(nz, 1);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; pstrb = 4'hF;
    fail_count = 0; tests_run = 0; cyc = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_fmt();
    t_interp();
    end_of_test();
  end
endmodule // ddcf_input_demux_tb_top
